// *** rtl/sdt_pkg.sv ***
// Operation
// - Eight-bit down counter, readable and writable; written value kept for reloading.
// - After a count write and start set, counting begins from the loaded value.
// - Underflow past zero raises an interrupt request toward the CPU.
// - After exception handling ends, counting restarts from the stored count value.
// - A newly written count value replaces the earlier starting point.
// - Underflow interval spans 1 to 256 counter input clocks.
// - Chip clock supply bit at one forwards oscillator clock to whole chip.
// - Chip clock supply bit at zero withholds chip clock; subtimer keeps running.
// - Counter input clock comes from software-set prescaler on oscillator output.
// - Oscillator output is also offered as the watchdog input clock.
package sdt_pkg;
    localparam logic [11:0] ADDR_COUNT = 12'h000;
    localparam logic [11:0] ADDR_CTRL = 12'h004;
    localparam logic [11:0] ADDR_DIV = 12'h008;
    localparam logic [11:0] ADDR_STAT = 12'h00c;
    localparam logic [11:0] ADDR_MASK = 12'h010;
    localparam logic [11:0] ADDR_LIVE = 12'h014;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_CLKSUP_BIT = 1;
    localparam int STAT_UNDER_BIT = 0;
    localparam int STAT_RELOAD_BIT = 1;
    localparam int DIV_W = 3;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [1:0] CTRL_RST = 2'h2;
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [7:0] PRE_RST = 8'h00;
    typedef enum logic [1:0] {SDT_IDLE, SDT_RUN, SDT_WAIT} sdt_state_e;
endpackage : sdt_pkg

// *** rtl/sdt_prescaler.sv ***
`timescale 1ns/1ns
// Divides oscillator ticks by 2^(div_sel+1), one-cycle tick out
module sdt_prescaler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic osc_tick,
    input wire logic run,
    input wire logic [sdt_pkg::DIV_W-1:0] div_sel,
    output logic cnt_tick
);
    logic [7:0] pre_r;
    logic [7:0] pre_nxt;
    logic cnt_tick_nxt;

    // Mask of low bits covering one full divided period
    function automatic logic [7:0] mask_of(input logic [sdt_pkg::DIV_W-1:0] sel);
        mask_of = 8'hff >> (3'h7 - sel);
    endfunction : mask_of

    // Free-running divider; held clear while stopped so periods start aligned
    always_comb begin
        pre_nxt = pre_r;
        cnt_tick_nxt = 1'b0;
        if (!run) begin
            pre_nxt = sdt_pkg::PRE_RST;
        end else if (osc_tick) begin
            pre_nxt = pre_r + 8'h01;
            cnt_tick_nxt = (pre_r[div_sel] == 1'b1) && ((pre_nxt & mask_of(div_sel)) == 8'h00);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r <= sdt_pkg::PRE_RST;
            cnt_tick <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            cnt_tick <= cnt_tick_nxt;
        end
    end
endmodule : sdt_prescaler

// *** rtl/sdt_subtimer.sv ***
`timescale 1ns/1ns
module sdt_subtimer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_tick,
    input wire logic exc_done,
    output logic irq,
    output logic chip_clk_en,
    output logic wdt_osc_tick
);
    logic [7:0] subtimer_count_value_r, subtimer_count_value_nxt;
    logic [7:0] live_r, live_nxt;
    logic [1:0] subtimer_control_r, subtimer_control_nxt;
    logic [sdt_pkg::DIV_W-1:0] subtimer_clock_divider_r, subtimer_clock_divider_nxt;
    logic [1:0] stat_r, stat_nxt;
    logic [1:0] mask_r, mask_nxt;
    logic [31:0] prdata_nxt;
    logic chip_clk_en_nxt, wdt_nxt;
    sdt_pkg::sdt_state_e state_r, state_nxt;
    logic cnt_tick, wr, rd, ev_under, ev_reload;

    // Zero wait state slave, every access completes in its access phase
    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign irq = |(stat_r & mask_r);

    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction : hit

    // Unmapped addresses answer with an error
    assign pslverr = psel && penable && !(hit(paddr, sdt_pkg::ADDR_COUNT)
        || hit(paddr, sdt_pkg::ADDR_CTRL) || hit(paddr, sdt_pkg::ADDR_DIV)
        || hit(paddr, sdt_pkg::ADDR_STAT) || hit(paddr, sdt_pkg::ADDR_MASK)
        || hit(paddr, sdt_pkg::ADDR_LIVE));

    sdt_prescaler u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .osc_tick(osc_tick),
        .run(subtimer_control_r[sdt_pkg::CTRL_START_BIT]),
        .div_sel(subtimer_clock_divider_r),
        .cnt_tick(cnt_tick)
    );

    // Counter sequencing and register writes
    always_comb begin
        subtimer_count_value_nxt = subtimer_count_value_r;
        subtimer_control_nxt = subtimer_control_r;
        subtimer_clock_divider_nxt = subtimer_clock_divider_r;
        mask_nxt = mask_r;
        live_nxt = live_r;
        state_nxt = state_r;
        ev_under = 1'b0;
        ev_reload = 1'b0;
        if (wr && hit(paddr, sdt_pkg::ADDR_COUNT)) begin
            subtimer_count_value_nxt = pwdata[7:0];
        end
        if (wr && hit(paddr, sdt_pkg::ADDR_CTRL)) begin
            subtimer_control_nxt = pwdata[1:0];
        end
        if (wr && hit(paddr, sdt_pkg::ADDR_DIV)) begin
            subtimer_clock_divider_nxt = pwdata[sdt_pkg::DIV_W-1:0];
        end
        if (wr && hit(paddr, sdt_pkg::ADDR_MASK)) begin
            mask_nxt = pwdata[1:0];
        end
        case (state_r)
            sdt_pkg::SDT_IDLE: begin
                if (subtimer_control_r[sdt_pkg::CTRL_START_BIT]) begin
                    live_nxt = subtimer_count_value_r;
                    state_nxt = sdt_pkg::SDT_RUN;
                end
            end
            sdt_pkg::SDT_RUN: begin
                if (wr && hit(paddr, sdt_pkg::ADDR_COUNT)) begin
                    live_nxt = pwdata[7:0];
                end else if (cnt_tick) begin
                    // Value N gives N+1 ticks to underflow, so 0..255 maps to 1..256
                    if (live_r == 8'h00) begin
                        ev_under = 1'b1;
                        state_nxt = sdt_pkg::SDT_WAIT;
                    end else begin
                        live_nxt = live_r - 8'h01;
                    end
                end
            end
            sdt_pkg::SDT_WAIT: begin
                // Stays parked at zero until the handler finishes
                if (exc_done) begin
                    live_nxt = subtimer_count_value_r;
                    ev_reload = 1'b1;
                    state_nxt = sdt_pkg::SDT_RUN;
                end
            end
            default: begin
                state_nxt = sdt_pkg::SDT_IDLE;
            end
        endcase
        if (!subtimer_control_nxt[sdt_pkg::CTRL_START_BIT]) begin
            state_nxt = sdt_pkg::SDT_IDLE;
        end
    end

    // Sticky status: set beats the read clear
    always_comb begin
        stat_nxt = stat_r;
        // Clear only what the read reported; a set landing after setup survives
        if (rd && hit(paddr, sdt_pkg::ADDR_STAT)) begin
            stat_nxt = stat_r & ~prdata[1:0];
        end
        stat_nxt[sdt_pkg::STAT_UNDER_BIT] = stat_nxt[sdt_pkg::STAT_UNDER_BIT] | ev_under;
        stat_nxt[sdt_pkg::STAT_RELOAD_BIT] = stat_nxt[sdt_pkg::STAT_RELOAD_BIT] | ev_reload;
    end

    // Read mux and clock gating outputs
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            if (hit(paddr, sdt_pkg::ADDR_COUNT)) prdata_nxt[7:0] = subtimer_count_value_r;
            if (hit(paddr, sdt_pkg::ADDR_CTRL)) prdata_nxt[1:0] = subtimer_control_r;
            if (hit(paddr, sdt_pkg::ADDR_DIV)) prdata_nxt[2:0] = subtimer_clock_divider_r;
            if (hit(paddr, sdt_pkg::ADDR_STAT)) prdata_nxt[1:0] = stat_r;
            if (hit(paddr, sdt_pkg::ADDR_MASK)) prdata_nxt[1:0] = mask_r;
            if (hit(paddr, sdt_pkg::ADDR_LIVE)) prdata_nxt[7:0] = live_r;
        end else if (psel && penable) begin
            prdata_nxt = prdata;
        end
        chip_clk_en_nxt = subtimer_control_r[sdt_pkg::CTRL_CLKSUP_BIT];
        wdt_nxt = osc_tick;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            subtimer_count_value_r <= sdt_pkg::COUNT_RST;
            live_r <= sdt_pkg::COUNT_RST;
            subtimer_control_r <= sdt_pkg::CTRL_RST;
            subtimer_clock_divider_r <= sdt_pkg::DIV_RST;
            stat_r <= 2'h0;
            mask_r <= sdt_pkg::MASK_RST;
            state_r <= sdt_pkg::SDT_IDLE;
            prdata <= 32'h0000_0000;
            chip_clk_en <= 1'b1;
            wdt_osc_tick <= 1'b0;
        end else begin
            subtimer_count_value_r <= subtimer_count_value_nxt;
            live_r <= live_nxt;
            subtimer_control_r <= subtimer_control_nxt;
            subtimer_clock_divider_r <= subtimer_clock_divider_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            state_r <= state_nxt;
            prdata <= prdata_nxt;
            chip_clk_en <= chip_clk_en_nxt;
            wdt_osc_tick <= wdt_nxt;
        end
    end
endmodule : sdt_subtimer

// *** testbench/sdt_checker.sv ***
`timescale 1ns/1ns
module sdt_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic osc_tick,
    input wire logic exc_done,
    input wire logic irq,
    input wire logic chip_clk_en,
    input wire logic wdt_osc_tick
);
    logic [7:0] cnt_w_r;
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    // Shadow of the last count written, so readback can be judged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt_w_r <= sdt_pkg::COUNT_RST;
        else if (wr && paddr == sdt_pkg::ADDR_COUNT) cnt_w_r <= pwdata[7:0];
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_zero_wait: assert property (acc |-> pready) else $error("pready low");
    a_unmapped_err: assert property (acc |-> pslverr ==
        (paddr > sdt_pkg::ADDR_LIVE || paddr[1:0] != 2'h0)) else $error("pslverr wrong");
    a_count_readback: assert property (acc && !pwrite && paddr == sdt_pkg::ADDR_COUNT
        |-> prdata == {24'h0, cnt_w_r}) else $error("count readback wrong");
    // Sampled reset keeps the release edge out; the flop is still held there
    a_wdt_follow: assert property (presetn |=> wdt_osc_tick == $past(osc_tick))
        else $error("watchdog tick wrong");
    // Enable sits two flops behind the write: control bit, then output
    a_supply_follow: assert property (wr && paddr == sdt_pkg::ADDR_CTRL
        |=> ##1 chip_clk_en == $past(pwdata[1], 2)) else $error("supply enable wrong");
    a_supply_hold: assert property (!(wr && paddr == sdt_pkg::ADDR_CTRL)
        |=> ##1 $stable(chip_clk_en)) else $error("supply enable moved");
    a_irq_drop: assert property ($fell(irq) |-> $past(acc && (pwrite ?
        paddr == sdt_pkg::ADDR_MASK : paddr == sdt_pkg::ADDR_STAT))) else $error("irq fell");
    a_mask_off: assert property (wr && paddr == sdt_pkg::ADDR_MASK && pwdata[1:0] == 2'h0
        |=> !irq) else $error("irq despite mask");
endmodule : sdt_checker
bind sdt_subtimer sdt_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_tick(osc_tick), .exc_done(exc_done),
    .irq(irq), .chip_clk_en(chip_clk_en), .wdt_osc_tick(wdt_osc_tick));

// *** testbench/sdt_cpu_model.sv ***
`timescale 1ns/1ns
// Interrupt side stand-in: ends handling a fixed delay after each new request
module sdt_cpu_model #(parameter int DELAY = 3) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic irq,
    output logic exc_done
);
    int cnt_r;
    logic irq_r;
    // A request held high is acknowledged only once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 0;
            irq_r <= 1'b0;
            exc_done <= 1'b0;
        end else begin
            irq_r <= irq;
            exc_done <= (cnt_r == 1);
            cnt_r <= (irq && !irq_r) ? DELAY : (cnt_r > 0 ? cnt_r - 1 : 0);
        end
    end
endmodule : sdt_cpu_model

// *** testbench/tb.sv ***
`timescale 1ns/1ns
module tb;
    typedef struct packed {logic [7:0] cnt; logic [2:0] dv;} sdt_row_s;
    localparam sdt_row_s ROWS [5] = '{'{8'h00, 3'h1}, '{8'h03, 3'h1}, '{8'h19, 3'h0},
        '{8'h00, 3'h7}, '{8'hff, 3'h0}};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic osc_tick = 1'b0, pready, pslverr, exc_done, irq, chip_clk_en, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q, v;
    int err_count = 0, n_tests = 0, cyc = 0, c, p;
    sdt_subtimer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_tick(osc_tick), .exc_done(exc_done), .irq(irq),
        .chip_clk_en(chip_clk_en), .wdt_osc_tick());
    sdt_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .irq(irq), .exc_done(exc_done));
    always #25 pclk = ~pclk;
    // Oscillator pulse every other cycle, so one count tick spans 4 << div cycles
    always @(posedge pclk) osc_tick <= ~osc_tick;
    // Hang guard, far above the slowest row
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One transfer; trailing idle edge keeps back-to-back calls apart
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wait_irq();
        for (c = 0; irq !== 1'b1; c++) @(posedge pclk);
    endtask : wait_irq
    task automatic wrap_up();
        if (err_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, sdt_pkg::ADDR_MASK, 32'h1);
        apb(1'b1, sdt_pkg::ADDR_CTRL, 32'h3);
        // Rewrite count while running; second period measured after a reload
        foreach (ROWS[i]) begin
            p = 4 << ROWS[i].dv;
            apb(1'b1, sdt_pkg::ADDR_DIV, {29'h0, ROWS[i].dv});
            apb(1'b1, sdt_pkg::ADDR_COUNT, {24'h0, ROWS[i].cnt});
            apb(1'b0, sdt_pkg::ADDR_STAT, 32'h0);
            wait_irq();
            apb(1'b0, sdt_pkg::ADDR_STAT, 32'h0);
            chk(q[0], 1'b1);
            wait_irq();
            chk(c >= ROWS[i].cnt * p && c <= (ROWS[i].cnt + 2) * p + 6, 1'b1);
            apb(1'b0, sdt_pkg::ADDR_STAT, 32'h0);
            chk(q[1:0], 2'h3);
        end
        // Chip clock withheld while the counter keeps moving
        apb(1'b1, sdt_pkg::ADDR_CTRL, 32'h1);
        @(posedge pclk);
        chk(chip_clk_en, 1'b0);
        apb(1'b0, sdt_pkg::ADDR_LIVE, 32'h0);
        v = q;
        repeat (20) @(posedge pclk);
        apb(1'b0, sdt_pkg::ADDR_LIVE, 32'h0);
        chk(q != v, 1'b1);
        // Start cleared: count frozen, chip clock back; restart reloads the count
        apb(1'b1, sdt_pkg::ADDR_CTRL, 32'h2);
        @(posedge pclk);
        chk(chip_clk_en, 1'b1);
        apb(1'b0, sdt_pkg::ADDR_LIVE, 32'h0);
        v = q;
        repeat (20) @(posedge pclk);
        apb(1'b0, sdt_pkg::ADDR_LIVE, 32'h0);
        chk(q, v);
        apb(1'b1, sdt_pkg::ADDR_CTRL, 32'h1);
        apb(1'b0, sdt_pkg::ADDR_LIVE, 32'h0);
        chk(q, 32'h0000_00ff);
        apb(1'b0, sdt_pkg::ADDR_COUNT, 32'h0);
        chk(q, 32'h0000_00ff);
        // Masked underflow still latches status but stays quiet
        apb(1'b1, sdt_pkg::ADDR_MASK, 32'h0);
        repeat (1100) @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b0, sdt_pkg::ADDR_STAT, 32'h0);
        chk(q[0], 1'b1);
        apb(1'b1, 12'h020, 32'hffffffff);
        chk(e, 1'b1);
        // Mid-run reset, then reset values of every register
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(chip_clk_en, 1'b1);
        for (int a = 0; a <= 20; a += 4) begin
            apb(1'b0, a[11:0], 32'h0);
            chk(q, (a == 4) ? {30'h0, sdt_pkg::CTRL_RST} : 32'h0);
        end
        wrap_up();
    end
endmodule : tb
